/* File: src/cpg_pkg.sv */
// Shared constants and types for the CPU priority gate and event channels
package cpg_pkg;
  // Sizes
  localparam int NUM_SRC   = 8;
  localparam int NUM_CHAN  = 8;
  localparam int LVL_W     = 4;
  localparam int GRP_W     = 2;
  localparam int PTR_W     = 24;

  // Register byte offsets (low 12 address bits decoded)
  localparam logic [11:0] PSW_OFF       = 12'h000;
  localparam logic [11:0] CHAN_BASE     = 12'h100;
  localparam logic [11:0] CHAN_STRIDE   = 12'h010;
  localparam logic [3:0]  CH_CTRL_OFF   = 4'h0;
  localparam logic [3:0]  CH_SRCP_OFF   = 4'h4;
  localparam logic [3:0]  CH_DSTP_OFF   = 4'h8;
  localparam logic [3:0]  CH_SEG_OFF    = 4'hC;

  // Status word fields
  localparam int PSW_LVL_LSB  = 12;
  localparam int PSW_IEN_BIT  = 11;
  localparam int PSW_HOLD_BIT = 10;
  localparam int PSW_USER_FLAG_ZERO_BIT = 6;
  localparam int PSW_MUL_BIT  = 5;
  localparam logic [15:0] PSW_RST     = 16'h0000;
  localparam logic [15:0] PSW_WR_MASK = 16'hFC7F;
  localparam logic [3:0]  LVL_MAX     = 4'hF;

  // Channel control fields
  localparam int CC_BWT_BIT = 8;
  localparam int CC_INC_LSB = 9;
  localparam int CC_CL_BIT  = 11;
  localparam int CC_CLT_BIT = 12;
  localparam int CC_PKT_BIT = 13;
  localparam logic [15:0] CC_RST      = 16'h0000;
  localparam logic [15:0] CC_WR_MASK  = 16'h3FFF;
  localparam logic [7:0]  CNT_CONT    = 8'hFF;
  localparam logic [7:0]  CNT_LAST    = 8'h01;
  localparam logic [7:0]  CNT_ZERO    = 8'h00;
  localparam logic [1:0]  INC_DST     = 2'h1;
  localparam logic [1:0]  INC_SRC     = 2'h2;
  localparam logic [1:0]  INC_BAD     = 2'h3;
  localparam int PKT_CHANS = 2;

  // Entry kinds
  localparam logic [1:0] KIND_IRQ  = 2'h0;
  localparam logic [1:0] KIND_HWTR = 2'h1;
  localparam logic [1:0] KIND_SWTR = 2'h2;

  // Entry sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01
  } cpg_state_t;
endpackage

/* File: src/cpg_gate.sv */
// CPU priority gate with status word and eight event transfer channels
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
// Function
// R01 - Status word low byte holds arithmetic flags, high byte holds interrupt and hold controls
// R02 - On interrupt entry the CPU level takes the serviced request's level
// R03 - The whole status word is pushed before the level changes
// R04 - Requests at or below the current CPU level are never acknowledged
// R05 - Software writes to the CPU level change acknowledgement from then on
// R06 - An event transfer steals one cycle and leaves the CPU level alone
// R07 - Hardware trap entry sets the CPU level to fifteen
// R08 - Software trap entry keeps the CPU level unchanged
// R09 - Global enable gates both event transfers and interrupt acceptance
// R10 - A request already taken in completes even if enable clears
// R11 - Setting global enable lets every individually enabled source request
// R12 - Hardware traps ignore the global enable
// R13 - Software allows for pipeline latency when toggling enables
// R14 - Eight channels each move one byte or word anywhere in memory
// R15 - Packet capability exists on channels 0 and 1 only
// R16 - Each channel has control, source and destination pointer registers
// R17 - Pointers are 24 bits wide
// R18 - One 16-bit segment register per channel holds both segment bytes
// R19 - Linked pairs hand over to the partner channel on termination
// R20 - Priority rises with the numeric level value
// R21 - Levels 15 and 14 use a channel unless its count is zero
// R22 - Only the highest enabled request above the CPU level is selected
module cpg_gate (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [7:0]  src_req,
  input  wire logic [31:0] src_lvl,
  input  wire logic [15:0] src_grp,
  output logic [7:0]       src_ack,
  input  wire logic        hw_trap,
  input  wire logic        sw_trap,
  input  wire logic        ret_valid,
  input  wire logic [15:0] ret_psw,
  input  wire logic        flags_we,
  input  wire logic [6:0]  flags_in,
  output logic             stack_push,
  output logic [15:0]      stack_data,
  output logic             irq_enter,
  output logic [1:0]       enter_kind,
  output logic [3:0]       irq_level,
  output logic [2:0]       irq_src,
  output logic             xfer_go,
  output logic [23:0]      xfer_src,
  output logic [23:0]      xfer_dst,
  output logic             xfer_byte,
  output logic             xfer_packet,
  output logic [2:0]       xfer_chan,
  output logic             link_event,
  output logic [2:0]       link_chan,
  output logic [15:0]      psw_out
);
  logic [15:0]         psw_reg;
  logic [15:0]         ctrl_reg [cpg_pkg::NUM_CHAN];
  logic [15:0]         srcp_reg [cpg_pkg::NUM_CHAN];
  logic [15:0]         dstp_reg [cpg_pkg::NUM_CHAN];
  logic [15:0]         seg_reg  [cpg_pkg::NUM_CHAN];
  cpg_pkg::cpg_state_t state_reg;
  logic [3:0]          pend_lvl_reg;
  logic [2:0]          pend_src_reg;
  logic [1:0]          pend_kind_reg;
  logic                wr_pend_reg;
  logic                rd_wait_reg;
  logic [11:0]         bus_addr_reg;
  logic [3:0]          cpu_lvl;
  logic                global_irq_enable;
  logic                addr_ok;
  logic                psw_wr;
  logic                best_found;
  logic [3:0]          best_lvl;
  logic [1:0]          best_grp;
  logic [2:0]          best_idx;
  logic                ev_lvl;
  logic [2:0]          ev_chan;
  logic                ev_go;
  logic                take_irq;
  logic [7:0]          cur_cnt;
  logic [23:0]         cur_src;
  logic [23:0]         cur_dst;
  logic [23:0]         step;
  logic                pair_linked;
  logic                hw_take;
  logic                sw_take;

  assign cpu_lvl = psw_reg[cpg_pkg::PSW_LVL_LSB +: cpg_pkg::LVL_W];
  assign global_irq_enable     = psw_reg[cpg_pkg::PSW_IEN_BIT];
  assign psw_out = psw_reg;
  assign hresp   = 1'b0;
  // Reads take one wait state so a write just before is always visible
  assign hreadyout = ~rd_wait_reg;
  assign addr_ok = hsel & htrans[1] & hready;
  assign psw_wr  = wr_pend_reg & (bus_addr_reg == cpg_pkg::PSW_OFF);

  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg  <= 1'b0;
      rd_wait_reg  <= 1'b0;
      bus_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      rd_wait_reg <= addr_ok & ~hwrite;
      if (addr_ok) begin
        bus_addr_reg <= haddr[11:0];
      end
    end
  end

  // Read data, latched in the wait cycle; unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait_reg) begin
      hrdata <= 32'h0000_0000;
      if (bus_addr_reg == cpg_pkg::PSW_OFF) begin
        hrdata <= {16'h0000, psw_reg};
      end
      for (int c = 0; c < cpg_pkg::NUM_CHAN; c++) begin
        if (bus_addr_reg[11:4] == 8'(c + 16)) begin
          case (bus_addr_reg[3:0])
            cpg_pkg::CH_CTRL_OFF: hrdata <= {16'h0000, ctrl_reg[c]};
            cpg_pkg::CH_SRCP_OFF: hrdata <= {16'h0000, srcp_reg[c]};
            cpg_pkg::CH_DSTP_OFF: hrdata <= {16'h0000, dstp_reg[c]};
            cpg_pkg::CH_SEG_OFF:  hrdata <= {16'h0000, seg_reg[c]};
            default:              hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Arbitration: highest level, then group, strictly above CPU level
  always_comb begin
    best_found = 1'b0;
    best_lvl   = 4'h0;
    best_grp   = 2'h0;
    best_idx   = 3'h0;
    for (int i = 0; i < cpg_pkg::NUM_SRC; i++) begin
      // A flag acknowledged at the last edge still reads set; skip it or it is served twice
      if (src_req[i] && !src_ack[i] && (src_lvl[4*i +: 4] > cpu_lvl) && // R04 R20
          (!best_found || ({src_lvl[4*i +: 4], src_grp[2*i +: 2]} >
                           {best_lvl, best_grp}))) begin           // R22
        best_found = 1'b1;
        best_lvl   = src_lvl[4*i +: 4];
        best_grp   = src_grp[2*i +: 2];
        best_idx   = 3'(i);
      end
    end
  end

  // Channel choice for levels 15/14; a linked pair follows its toggle
  always_comb begin
    ev_lvl      = (best_lvl[3:1] == 3'b111);                       // R21
    pair_linked = ctrl_reg[{best_lvl[0], best_grp[1], 1'b0}][cpg_pkg::CC_CL_BIT] |
                  ctrl_reg[{best_lvl[0], best_grp[1], 1'b1}][cpg_pkg::CC_CL_BIT];
    ev_chan     = {best_lvl[0], best_grp};
    if (pair_linked) begin
      ev_chan[0] = ctrl_reg[{best_lvl[0], best_grp[1], 1'b0}][cpg_pkg::CC_CLT_BIT]; // R19
    end
    cur_cnt = ctrl_reg[ev_chan][7:0];
    cur_src = {seg_reg[ev_chan][7:0], srcp_reg[ev_chan]};          // R17 R18
    cur_dst = {seg_reg[ev_chan][15:8], dstp_reg[ev_chan]};
    step    = ctrl_reg[ev_chan][cpg_pkg::CC_BWT_BIT] ? 24'h000001 : 24'h000002;
  end

  // Service decisions, only from idle; transfers and interrupts only while enabled, traps regardless
  assign ev_go    = (state_reg == cpg_pkg::ST_IDLE) & ~hw_trap & global_irq_enable & best_found &
                    ev_lvl & (cur_cnt != cpg_pkg::CNT_ZERO);       // R09 R21
  assign take_irq = global_irq_enable & best_found & ~ev_go;                     // R09 R11
  // A held trap line still reads high in its own entry cycle; do not take it twice
  assign hw_take  = hw_trap & ~(irq_enter & (enter_kind == cpg_pkg::KIND_HWTR)); // R12
  assign sw_take  = sw_trap & ~(irq_enter & (enter_kind == cpg_pkg::KIND_SWTR)); // R08

  // Entry sequencer: push the status word, then load the new level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= cpg_pkg::ST_IDLE;
      pend_lvl_reg  <= 4'h0;
      pend_src_reg  <= 3'h0;
      pend_kind_reg <= cpg_pkg::KIND_IRQ;
      stack_push    <= 1'b0;
      stack_data    <= 16'h0000;
      irq_enter     <= 1'b0;
      enter_kind    <= cpg_pkg::KIND_IRQ;
      irq_level     <= 4'h0;
      irq_src       <= 3'h0;
    end else begin
      stack_push <= 1'b0;
      irq_enter  <= 1'b0;
      case (state_reg)
        cpg_pkg::ST_IDLE: begin
          if (hw_take || sw_take || take_irq) begin              // R12
            state_reg   <= cpg_pkg::ST_PUSH;
            stack_push  <= 1'b1;                                 // R03
            stack_data  <= psw_reg;
            pend_src_reg <= best_idx;
            if (hw_take) begin
              pend_kind_reg <= cpg_pkg::KIND_HWTR;
              pend_lvl_reg  <= cpg_pkg::LVL_MAX;                 // R07
            end else if (sw_take) begin
              pend_kind_reg <= cpg_pkg::KIND_SWTR;
              pend_lvl_reg  <= cpu_lvl;                          // R08
            end else begin
              pend_kind_reg <= cpg_pkg::KIND_IRQ;
              pend_lvl_reg  <= best_lvl;                         // R02
            end
          end
        end
        cpg_pkg::ST_PUSH: begin
          // Already taken in: finishes even if the enable was just cleared
          state_reg  <= cpg_pkg::ST_IDLE;                        // R10
          irq_enter  <= 1'b1;
          enter_kind <= pend_kind_reg;
          irq_level  <= pend_lvl_reg;
          irq_src    <= pend_src_reg;
        end
        default: state_reg <= cpg_pkg::ST_IDLE;
      endcase
    end
  end

  // Status word; hardware entry beats a same-cycle software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psw_reg <= cpg_pkg::PSW_RST;
    end else if (state_reg == cpg_pkg::ST_PUSH) begin
      psw_reg[cpg_pkg::PSW_LVL_LSB +: cpg_pkg::LVL_W] <= pend_lvl_reg; // R02 R07 R08
    end else if (ret_valid) begin
      psw_reg <= ret_psw & cpg_pkg::PSW_WR_MASK;
    end else if (psw_wr) begin
      psw_reg <= hwdata[15:0] & cpg_pkg::PSW_WR_MASK;            // R05 R01
    end else if (flags_we) begin
      psw_reg[6:0] <= flags_in;                                  // R01
    end
  end

  // Acknowledge pulses back to the sources
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_ack <= 8'h00;
    end else begin
      src_ack <= 8'h00;
      if (state_reg == cpg_pkg::ST_PUSH && pend_kind_reg == cpg_pkg::KIND_IRQ) begin
        src_ack[pend_src_reg] <= 1'b1;
      end else if (ev_go && cur_cnt != cpg_pkg::CNT_LAST) begin
        // Last transfer leaves the request up so an interrupt follows
        src_ack[best_idx] <= 1'b1;
      end
    end
  end

  // One stolen cycle per transfer, level untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_go     <= 1'b0;
      xfer_src    <= 24'h000000;
      xfer_dst    <= 24'h000000;
      xfer_byte   <= 1'b0;
      xfer_packet <= 1'b0;
      xfer_chan   <= 3'h0;
      link_event  <= 1'b0;
      link_chan   <= 3'h0;
    end else begin
      xfer_go    <= ev_go;                                       // R06 R14
      link_event <= 1'b0;
      if (ev_go) begin
        xfer_src    <= cur_src;
        xfer_dst    <= cur_dst;
        xfer_byte   <= ctrl_reg[ev_chan][cpg_pkg::CC_BWT_BIT];
        xfer_packet <= ctrl_reg[ev_chan][cpg_pkg::CC_PKT_BIT];   // R15
        xfer_chan   <= ev_chan;
        if (pair_linked && cur_cnt == cpg_pkg::CNT_LAST) begin
          link_event <= 1'b1;                                    // R19
          link_chan  <= ev_chan;
        end
      end
    end
  end

  // Channel registers: bus writes, then transfer updates on top
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < cpg_pkg::NUM_CHAN; c++) begin
        ctrl_reg[c] <= cpg_pkg::CC_RST;
        srcp_reg[c] <= 16'h0000;
        dstp_reg[c] <= 16'h0000;
        seg_reg[c]  <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < cpg_pkg::NUM_CHAN; c++) begin
        if (wr_pend_reg && bus_addr_reg[11:4] == 8'(c + 16)) begin   // R16
          case (bus_addr_reg[3:0])
            cpg_pkg::CH_CTRL_OFF: begin
              ctrl_reg[c] <= hwdata[15:0] & cpg_pkg::CC_WR_MASK;
              if (hwdata[cpg_pkg::CC_INC_LSB +: 2] == cpg_pkg::INC_BAD) begin
                ctrl_reg[c][cpg_pkg::CC_INC_LSB +: 2] <= cpg_pkg::INC_SRC;
              end
              if (c >= cpg_pkg::PKT_CHANS) begin
                ctrl_reg[c][cpg_pkg::CC_PKT_BIT] <= 1'b0;        // R15
              end
            end
            cpg_pkg::CH_SRCP_OFF: srcp_reg[c] <= hwdata[15:0];
            cpg_pkg::CH_DSTP_OFF: dstp_reg[c] <= hwdata[15:0];
            cpg_pkg::CH_SEG_OFF:  seg_reg[c]  <= hwdata[15:0];   // R18
            default: ;
          endcase
        end
      end
      if (ev_go) begin
        if (cur_cnt != cpg_pkg::CNT_CONT) begin
          ctrl_reg[ev_chan][7:0] <= cur_cnt - 8'h01;
        end
        if (ctrl_reg[ev_chan][cpg_pkg::CC_INC_LSB +: 2] == cpg_pkg::INC_DST) begin
          {seg_reg[ev_chan][15:8], dstp_reg[ev_chan]} <= cur_dst + step;  // R17
        end else if (ctrl_reg[ev_chan][cpg_pkg::CC_INC_LSB +: 2] == cpg_pkg::INC_SRC) begin
          {seg_reg[ev_chan][7:0], srcp_reg[ev_chan]} <= cur_src + step;
        end
        // Block done on a linked pair: hand over to the partner
        if (pair_linked && cur_cnt == cpg_pkg::CNT_LAST) begin
          ctrl_reg[{ev_chan[2:1], 1'b0}][cpg_pkg::CC_CLT_BIT] <= ~ev_chan[0]; // R19
          ctrl_reg[{ev_chan[2:1], 1'b1}][cpg_pkg::CC_CLT_BIT] <= ~ev_chan[0];
        end
      end
    end
  end

  // Checks on the priority gate and the transfer path
  push_first_a: assert property (@(posedge hclk) disable iff (!hresetn) // R03
    irq_enter |-> $past(stack_push) && $past(stack_data) == $past(psw_reg, 2))
    else $error("entry without prior status push");
  enter_level_a: assert property (@(posedge hclk) disable iff (!hresetn) // R02
    irq_enter && enter_kind == cpg_pkg::KIND_IRQ |-> cpu_lvl == irq_level)
    else $error("level not loaded on entry");
  trap_level_a: assert property (@(posedge hclk) disable iff (!hresetn) // R07
    irq_enter && enter_kind == cpg_pkg::KIND_HWTR |-> cpu_lvl == 4'hF)
    else $error("hardware trap did not raise level");
  swtrap_keep_a: assert property (@(posedge hclk) disable iff (!hresetn) // R08
    irq_enter && enter_kind == cpg_pkg::KIND_SWTR |-> cpu_lvl == $past(cpu_lvl, 2))
    else $error("software trap changed level");
  above_level_a: assert property (@(posedge hclk) disable iff (!hresetn) // R04
    stack_push && pend_kind_reg == cpg_pkg::KIND_IRQ |-> pend_lvl_reg > $past(cpu_lvl))
    else $error("request at or below level taken");
  xfer_keep_a: assert property (@(posedge hclk) disable iff (!hresetn) // R06
    xfer_go |=> !xfer_go || $past(ev_go))
    else $error("transfer held more than its cycle");
  xfer_lvl_a: assert property (@(posedge hclk) disable iff (!hresetn) // R06
    ev_go && !psw_wr && !ret_valid |=> $stable(cpu_lvl))
    else $error("transfer changed level");
  enable_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // R09
    xfer_go || (stack_push && $past(pend_kind_reg) != 2'h3 &&
                pend_kind_reg == cpg_pkg::KIND_IRQ) |-> $past(global_irq_enable))
    else $error("service while disabled");
  trap_nomask_a: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    hw_take && state_reg == cpg_pkg::ST_IDLE |=> stack_push ##1 irq_enter)
    else $error("hardware trap not taken");
  packet_chan_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    xfer_go && xfer_packet |-> xfer_chan < 3'h2)
    else $error("packet transfer on wrong channel");
  cov_irq_c: cover property (@(posedge hclk) irq_enter && enter_kind == cpg_pkg::KIND_IRQ);
  cov_xfer_c: cover property (@(posedge hclk) xfer_go);
  cov_link_c: cover property (@(posedge hclk) link_event);
  cov_trap_c: cover property (@(posedge hclk) irq_enter && enter_kind == cpg_pkg::KIND_HWTR);
endmodule

/* File: verif/cpg_far_side.sv */
// Far-side model: request flags of the sources and trap lines of the core
`timescale 1ns/1ns
module cpg_far_side (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] trig,
  input  wire logic       hw_go,
  input  wire logic       sw_go,
  input  wire logic [7:0] src_ack,
  input  wire logic       irq_enter,
  input  wire logic [1:0] enter_kind,
  output logic      [7:0] src_req,
  output logic            hw_trap,
  output logic            sw_trap
);
  // A flag stays set until acknowledged, so a refused request keeps asking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_req <= 8'h00;
    end else begin
      src_req <= (src_req & ~src_ack) | trig;
    end
  end

  // Trap lines are held until the core enters the routine of that kind
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hw_trap <= 1'b0;
      sw_trap <= 1'b0;
    end else begin
      hw_trap <= hw_go | (hw_trap & ~(irq_enter & (enter_kind == cpg_pkg::KIND_HWTR)));
      sw_trap <= sw_go | (sw_trap & ~(irq_enter & (enter_kind == cpg_pkg::KIND_SWTR)));
    end
  end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the priority gate and event channels
`timescale 1ns/1ns
module tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, enter_kind;
  logic [2:0]  hsize = 3'h2, irq_src, xfer_chan, link_chan;
  logic [31:0] src_lvl = 32'h0;
  logic [15:0] src_grp = 16'h0, stack_data, psw_out, push_data;
  logic [7:0]  src_req, src_ack, trig = 8'h00, e_ack;
  logic        hreadyout, hresp, hw_trap, sw_trap, hw_go = 1'b0, sw_go = 1'b0;
  logic        stack_push, irq_enter, xfer_go, xfer_byte, xfer_packet, link_event;
  logic [3:0]  irq_level;
  logic [23:0] xfer_src, xfer_dst;
  int          bad_count = 0, samples_checked = 0, ack_cnt = 0, n0, s1, s2, l1, l2;

  always #5 hclk = ~hclk;

  cpg_gate u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_req(src_req),
    .src_lvl(src_lvl), .src_grp(src_grp), .src_ack(src_ack), .hw_trap(hw_trap),
    .sw_trap(sw_trap), .ret_valid(1'b0), .ret_psw(16'h0000), .flags_we(1'b0),
    .flags_in(7'h00), .stack_push(stack_push), .stack_data(stack_data),
    .irq_enter(irq_enter), .enter_kind(enter_kind), .irq_level(irq_level),
    .irq_src(irq_src), .xfer_go(xfer_go), .xfer_src(xfer_src), .xfer_dst(xfer_dst),
    .xfer_byte(xfer_byte), .xfer_packet(xfer_packet), .xfer_chan(xfer_chan),
    .link_event(link_event), .link_chan(link_chan), .psw_out(psw_out));

  cpg_far_side u_far (.hclk(hclk), .hresetn(hresetn), .trig(trig), .hw_go(hw_go),
    .sw_go(sw_go), .src_ack(src_ack), .irq_enter(irq_enter), .enter_kind(enter_kind),
    .src_req(src_req), .hw_trap(hw_trap), .sw_trap(sw_trap));

  // Acknowledge tally and the status word seen on the stack
  always @(posedge hclk) begin
    ack_cnt <= ack_cnt + $countones(src_ack);
    if (stack_push === 1'b1) push_data <= stack_data;
  end

  function automatic logic [15:0] psw_val(input logic [3:0] lvl, input logic en);
    return {lvl, en, 11'h000};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One single AHB transfer; a wait ends only when the slave answers
  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {16'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 16'h0, r);
    chk(r, exp);
  endtask

  task automatic fire(input logic [7:0] m, input logic hw, input logic sw);
    trig <= m; hw_go <= hw; sw_go <= sw;
    @(posedge hclk);
    trig <= 8'h00; hw_go <= 1'b0; sw_go <= 1'b0;
  endtask

  // Wait for an entry (x=0) or a transfer (x=1) and check what it carries
  task automatic wait_evt(input logic x, input logic [31:0] a, input logic [31:0] b);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((x ? xfer_go : irq_enter) !== 1'b1 && n < 40);
    e_ack = src_ack;
    chk(x ? {xfer_chan, xfer_byte} : {enter_kind, irq_level, irq_src}, a);
    chk(x ? {xfer_src, 8'h00} : {psw_out[15:12], e_ack}, b);
  endtask

  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(11));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(cpg_pkg::PSW_OFF, 32'h0000);
    rd(12'hFFC, 32'h0000);
    wr(cpg_pkg::PSW_OFF, 16'hFFFF);
    rd(cpg_pkg::PSW_OFF, {16'h0, cpg_pkg::PSW_WR_MASK});
    // Every channel: packet bit only on the first pair, reserved increment folds to source
    for (int c = 0; c < 8; c++) begin
      wr(cpg_pkg::CHAN_BASE + 12'(16 * c), 16'h2600 | 16'(c));
      rd(cpg_pkg::CHAN_BASE + 12'(16 * c), (c < 2 ? 32'h2400 : 32'h0400) | c);
      wr(cpg_pkg::CHAN_BASE + 12'(16 * c + 12), {8'(c), ~8'(c)});
      rd(cpg_pkg::CHAN_BASE + 12'(16 * c + 12), {16'h0, 8'(c), ~8'(c)});
    end
    wr(cpg_pkg::PSW_OFF, psw_val(4'h0, 1'b1));
    src_lvl[15:12] <= 4'h5;
    fire(8'h08, 1'b0, 1'b0);
    wait_evt(1'b0, {2'h0, 4'h5, 3'h3}, {4'h5, 8'h08});
    chk(push_data, psw_val(4'h0, 1'b1));
    // Equal level is refused until software lowers the CPU level
    @(posedge hclk);
    n0 = ack_cnt;
    src_lvl[11:8] <= 4'h5;
    fire(8'h04, 1'b0, 1'b0);
    repeat (12) @(posedge hclk);
    chk(ack_cnt, n0);
    wr(cpg_pkg::PSW_OFF, psw_val(4'h4, 1'b1));
    wait_evt(1'b0, {2'h0, 4'h5, 3'h2}, {4'h5, 8'h04});
    // Global enable off: no acceptance, traps still taken
    wr(cpg_pkg::PSW_OFF, psw_val(4'h0, 1'b0));
    n0 = ack_cnt;
    src_lvl[19:16] <= 4'h7;
    fire(8'h10, 1'b0, 1'b0);
    repeat (12) @(posedge hclk);
    chk(ack_cnt, n0);
    fire(8'h00, 1'b1, 1'b0);
    wait_evt(1'b0, {2'h1, 4'hF, 3'h4}, {4'hF, 8'h00});
    wr(cpg_pkg::PSW_OFF, psw_val(4'h3, 1'b0));
    fire(8'h00, 1'b0, 1'b1);
    wait_evt(1'b0, {2'h2, 4'h3, 3'h4}, {4'h3, 8'h00});
    wr(cpg_pkg::PSW_OFF, psw_val(4'h0, 1'b1));
    wait_evt(1'b0, {2'h0, 4'h7, 3'h4}, {4'h7, 8'h10});
    // Channel 1 runs three transfers, then the request falls to the CPU
    wr(cpg_pkg::PSW_OFF, psw_val(4'h0, 1'b1));
    wr(cpg_pkg::CHAN_BASE + 12'h010, 16'h2203);
    wr(cpg_pkg::CHAN_BASE + 12'h014, 16'h1234);
    wr(cpg_pkg::CHAN_BASE + 12'h018, 16'h5678);
    wr(cpg_pkg::CHAN_BASE + 12'h01C, 16'hBBAA);
    src_lvl[3:0] <= 4'hE;
    src_grp[1:0] <= 2'h1;
    for (int k = 0; k < 3; k++) begin
      fire(8'h01, 1'b0, 1'b0);
      wait_evt(1'b1, {3'h1, 1'b0}, {24'hAA1234, 8'h00});
      chk(xfer_dst, 24'hBB5678 + 24'(2 * k));
      chk(psw_out, psw_val(4'h0, 1'b1));
      chk(xfer_packet, 1'b1);
    end
    wait_evt(1'b0, {2'h0, 4'hE, 3'h0}, {4'hE, 8'h01});
    rd(cpg_pkg::CHAN_BASE + 12'h010, 32'h2200);
    // Linked pair 2/3, one word per block: each finished block hands over
    wr(cpg_pkg::PSW_OFF, psw_val(4'h0, 1'b1));
    wr(cpg_pkg::CHAN_BASE + 12'h020, 16'h0801);
    wr(cpg_pkg::CHAN_BASE + 12'h030, 16'h0001);
    src_grp[1:0] <= 2'h2;
    fire(8'h01, 1'b0, 1'b0);
    for (int k = 2; k < 4; k++) begin
      wait_evt(1'b1, {3'(k), 1'b0}, {~8'(k), 24'h000000});
      chk({link_event, link_chan}, {1'b1, 3'(k)});
    end
    wait_evt(1'b0, {2'h0, 4'hE, 3'h0}, {4'hE, 8'h01});
    src_lvl <= 32'h0;
    // Random pairs at distinct levels: the higher wins, the other follows
    for (int i = 0; i < 6; i++) begin
      s1 = $urandom % 8;
      s2 = (s1 + 1 + $urandom % 7) % 8;
      l1 = 1 + $urandom % 13;
      l2 = 1 + (l1 + $urandom % 12) % 13;
      wr(cpg_pkg::PSW_OFF, psw_val(4'h0, 1'b1));
      src_lvl[4*s1+:4] <= 4'(l1);
      src_lvl[4*s2+:4] <= 4'(l2);
      fire(8'(1 << s1) | 8'(1 << s2), 1'b0, 1'b0);
      if (l1 < l2) begin
        n0 = s1; s1 = s2; s2 = n0; n0 = l1; l1 = l2; l2 = n0;
      end
      wait_evt(1'b0, {2'h0, 4'(l1), 3'(s1)}, {4'(l1), 8'(1 << s1)});
      wr(cpg_pkg::PSW_OFF, psw_val(4'h0, 1'b1));
      wait_evt(1'b0, {2'h0, 4'(l2), 3'(s2)}, {4'(l2), 8'(1 << s2)});
    end
    print_verdict();
  end
endmodule
